// file: mrf_formatter.sv
// Measurement result formatter: tabulated, compressed and dump output
`timescale 1ns/1ps
`include "mrf_map.svh"
// Functional notes
// - Every serial result line ends with one carriage return only.
// - Serial lines are tabulated, under 80 characters, heading optional.
// - Columns: frequency, real/mag, imag/phase, limit, channel, time status.
// - Broadcast switch on: bus gets tabulated lines with bus terminator.
// - Broadcast switch off: bus gets compressed controller form.
// - Numeric field is 11 chars: sign, d.dddd, E, signed 2 digits.
// - Compressed: frequency, two coordinates, error code, separators, term.
// - Error code is one digit; group 8 reports its last digit.
// - Default separator is comma, default compressed terminator CR-based.
// - Bus values follow the displayed channel and coordinates.
// - Selection: all, failing only, passing only; dump is separate.
// - Dump packs a reading into 12 bytes: three 4-byte floats.
// - With an EOI terminator, EOI rides on the twelfth dump byte.
// - Dump sends no terminator and no separator characters.
// - Float byte one top bit is the sign: 0 positive, 1 negative.
// - Float byte one low seven bits: two's complement exponent.
// - Bytes two to four hold a fraction mantissa below one.
// - Bus bytes go out about one per millisecond.
// - Continuous mode may lose readings if the controller lags.
// - Bus terminator: CR LF, CR LF EOI, CR, or CR EOI.
// - Bus separator: comma or the terminator characters.
module mrf_formatter
   import mrf_pkg::*;
#(
   parameter int BYTE_CYC = `MRF_BYTE_TIME_US * `MRF_CLK_MHZ
)
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Reading in
   input  wire logic       rd_valid,
   output logic            rd_ready,
   output logic            rd_lost,
   input  wire mrf_num_t   freq_num,
   input  wire mrf_num_t   a_num,
   input  wire mrf_num_t   b_num,
   input  wire mrf_flt_t   a_flt,
   input  wire mrf_flt_t   b_flt,
   input  wire mrf_flt_t   f_flt,
   input  wire logic [7:0] err_code,
   input  wire logic       lim_fail,
   input  wire logic [7:0] chan_rng,
   input  wire logic [7:0] time_stat,
   // Configuration
   input  wire logic       port_bus,
   input  wire mrf_osel_t  out_sel,
   input  wire mrf_term_t  term_sel,
   input  wire logic       sep_term,
   input  wire logic       hdr_en,
   input  wire logic       continuous_measure_mode,
   input  wire logic       printer_broadcast_switch,
   // Serial port bytes
   output logic [7:0]      ser_data,
   output logic            ser_valid,
   input  wire logic       ser_ready,
   // Instrument bus bytes
   output logic [7:0]      bus_data,
   output logic            bus_eoi,
   output logic            bus_valid,
   input  wire logic       bus_ready
);
   localparam logic [8*`MRF_LEN_HEAD-1:0] HEAD = `MRF_HEAD_STR;

   typedef struct packed {
      mrf_st_t    st;
      mrf_fmt_t   fmt;
      logic       dst;
      mrf_term_t  term;
      logic       sep_term;
      logic [3:0] seg;
      logic [5:0] sub;
      mrf_num_t   fn;
      mrf_num_t   an;
      mrf_num_t   bn;
      mrf_flt_t   af;
      mrf_flt_t   bf;
      mrf_flt_t   ff;
      logic [3:0] err;
      logic       lim;
      logic [7:0] chan;
      logic [7:0] ts;
      logic       hdr;
      logic       hden;
      logic       credit;
      logic       pb_s1;
      logic       pb_s2;
   } mrf_fmt_state_t;

   mrf_fmt_state_t q;
   mrf_fmt_state_t d;
   mrf_kind_t      kind;
   logic [5:0]     tlen;
   logic [5:0]     len;
   logic           last;
   logic           eoi_on;
   logic [7:0]     chr;
   logic           keep;
   mrf_fmt_t       fmt_new;
   logic           tick;
   logic           push;

   mrf_byte_if fmt_if ();
   mrf_byte_if out_if ();

   function automatic logic [7:0] dchr(input logic [3:0] v);
      return `MRF_CH_ZERO + {4'h0, v};
   endfunction

   // Fixed 11-character field, decimal point after the first digit
   function automatic logic [7:0] num_char(input mrf_num_t n,
                                           input logic [5:0] i);
      logic [7:0] c;
      c = `MRF_CH_SP;
      case (i)
         6'h00:   c = n.sign ? `MRF_CH_MINUS : `MRF_CH_PLUS;
         6'h01:   c = dchr(n.dig[4]);
         6'h02:   c = `MRF_CH_DOT;
         6'h03:   c = dchr(n.dig[3]);
         6'h04:   c = dchr(n.dig[2]);
         6'h05:   c = dchr(n.dig[1]);
         6'h06:   c = dchr(n.dig[0]);
         6'h07:   c = `MRF_CH_E;
         6'h08:   c = n.esign ? `MRF_CH_MINUS : `MRF_CH_PLUS;
         6'h09:   c = dchr(n.exd[1]);
         6'h0a:   c = dchr(n.exd[0]);
         default: c = `MRF_CH_SP;
      endcase
      return c;
   endfunction

   function automatic mrf_kind_t seg_kind(input mrf_fmt_t f,
                                          input logic [3:0] s);
      mrf_kind_t k;
      k = K_END;
      case (f)
         MRF_FMT_DMP:
            k = (s == `MRF_SEG_FIRST) ? K_BIN : K_END;
         MRF_FMT_CMP:
            case (s)
               4'h0:    k = K_F0;
               4'h1:    k = K_SEP;
               4'h2:    k = K_F1;
               4'h3:    k = K_SEP;
               4'h4:    k = K_F2;
               4'h5:    k = K_SEP;
               4'h6:    k = K_ERR;
               4'h7:    k = K_TERM;
               default: k = K_END;
            endcase
         MRF_FMT_TAB:
            case (s)
               4'h0:           k = K_F0;
               4'h2:           k = K_F1;
               4'h4:           k = K_F2;
               4'h6:           k = K_LIM;
               4'h8:           k = K_CH;
               4'ha:           k = K_TS;
               4'h1, 4'h3, 4'h5, 4'h7, 4'h9:
                               k = K_SP;
               4'hb:           k = K_TERM;
               `MRF_SEG_HEAD:  k = K_HEAD;
               `MRF_SEG_HTERM: k = K_TERM;
               default:        k = K_END;
            endcase
         default: k = K_END;
      endcase
      return k;
   endfunction

   // Dump byte: exponent byte then three mantissa bytes per float
   function automatic logic [7:0] bin_byte(input mrf_flt_t a,
                                           input mrf_flt_t b,
                                           input mrf_flt_t f,
                                           input logic [5:0] i);
      mrf_flt_t w;
      logic [7:0] c;
      case (i[3:2])
         2'h0:    w = a;
         2'h1:    w = b;
         default: w = f;
      endcase
      case (i[1:0])
         2'h0:    c = {w.sign, w.expo};
         2'h1:    c = w.mant[23:16];
         2'h2:    c = w.mant[15:8];
         default: c = w.mant[7:0];
      endcase
      return c;
   endfunction

   mrf_pace #(
      .CYC (BYTE_CYC)
   ) u_pace (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (tick)
   );

   mrf_buf2 #(
      .DEPTH (2)
   ) u_buf (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .in_s    (fmt_if.snk),
      .out_s   (out_if.src)
   );

   // Serial head-of-line byte stalls bus bytes behind it, and back
   assign ser_data     = out_if.data;
   assign ser_valid    = out_if.valid && !out_if.dst;
   assign bus_data     = out_if.data;
   assign bus_eoi      = out_if.eoi && out_if.dst;
   assign bus_valid    = out_if.valid && out_if.dst;
   assign out_if.ready = out_if.dst ? bus_ready : ser_ready;

   // In one-shot use the source holds its reading until taken
   assign rd_ready = q.st == MRF_IDLE;
   assign rd_lost  = rd_valid && !rd_ready && continuous_measure_mode;

   always_comb
   begin
      kind = seg_kind(q.fmt, q.seg);
      tlen = (q.dst && (q.term == MRF_TERM_CRLF ||
                        q.term == MRF_TERM_CRLF_EOI))
             ? `MRF_LEN_CRLF : `MRF_LEN_ONE;
      eoi_on = q.dst && (q.term == MRF_TERM_CRLF_EOI ||
                         q.term == MRF_TERM_CR_EOI);
      case (kind)
         K_F0, K_F1, K_F2: len = `MRF_LEN_NUM;
         K_SEP:   len = q.sep_term ? tlen : `MRF_LEN_ONE;
         K_TERM:  len = tlen;
         K_CH:    len = `MRF_LEN_CHAN;
         K_BIN:   len = `MRF_LEN_BIN;
         K_HEAD:  len = `MRF_LEN_HEAD;
         default: len = `MRF_LEN_ONE;
      endcase
      last = q.sub == len - `MRF_LEN_ONE;
      case (kind)
         K_F0:    chr = num_char(q.fn, q.sub);
         K_F1:    chr = num_char(q.an, q.sub);
         K_F2:    chr = num_char(q.bn, q.sub);
         K_SEP:   chr = !q.sep_term ? `MRF_CH_COMMA :
                        (q.sub == '0) ? `MRF_CH_CR : `MRF_CH_LF;
         K_SP:    chr = `MRF_CH_SP;
         K_ERR:   chr = dchr(q.err);
         K_LIM:   chr = q.lim ? `MRF_CH_FAIL : `MRF_CH_PASS;
         K_CH:    chr = dchr((q.sub == '0) ? q.chan[7:4] : q.chan[3:0]);
         K_TS:    chr = q.ts;
         K_TERM:  chr = (q.sub == '0) ? `MRF_CH_CR : `MRF_CH_LF;
         K_BIN:   chr = bin_byte(q.af, q.bf, q.ff, q.sub);
         K_HEAD:  chr = HEAD[8*(int'(`MRF_LEN_HEAD) - 1 - int'(q.sub)) +: 8];
         default: chr = `MRF_CH_SP;
      endcase
   end

   // Stream toward the buffer; bus bytes wait for a pacing credit
   assign fmt_if.data  = chr;
   assign fmt_if.dst   = q.dst;
   assign fmt_if.eoi   = last && eoi_on &&
                         (kind == K_TERM || kind == K_BIN);
   assign fmt_if.valid = q.st == MRF_RUN && kind != K_END &&
                         (!q.dst || q.credit);
   assign push         = fmt_if.valid && fmt_if.ready;

   always_comb
   begin
      case (out_sel)
         MRF_SEL_FAIL: keep = lim_fail;
         MRF_SEL_PASS: keep = !lim_fail;
         default:      keep = 1'b1;
      endcase
      if (port_bus && out_sel == MRF_SEL_DUMP)
         fmt_new = MRF_FMT_DMP;
      else if (port_bus && !q.pb_s2)
         fmt_new = MRF_FMT_CMP;
      else
         fmt_new = MRF_FMT_TAB;
   end

   always_comb
   begin
      d       = q;
      d.pb_s1 = printer_broadcast_switch;
      d.pb_s2 = q.pb_s1;
      d.hden  = hdr_en;
      if (hdr_en && !q.hden)
         d.hdr = 1'b1;
      if (tick)
         d.credit = 1'b1;
      case (q.st)
         MRF_IDLE:
            if (rd_valid && keep)
            begin
               // Values arrive already in displayed channel and coordinates
               d.fn       = freq_num;
               d.an       = a_num;
               d.bn       = b_num;
               d.af       = a_flt;
               d.bf       = b_flt;
               d.ff       = f_flt;
               d.err      = err_code[3:0];
               d.lim      = lim_fail;
               d.chan     = chan_rng;
               d.ts       = time_stat;
               d.dst      = port_bus;
               d.fmt      = fmt_new;
               d.term     = term_sel;
               d.sep_term = sep_term;
               d.sub      = '0;
               d.seg      = `MRF_SEG_FIRST;
               d.st       = MRF_RUN;
               if (fmt_new == MRF_FMT_TAB && q.hdr && hdr_en)
               begin
                  d.seg = `MRF_SEG_HEAD;
                  d.hdr = 1'b0;
               end
            end
         MRF_RUN:
            if (kind == K_END)
               d.st = MRF_IDLE;
            else if (push)
            begin
               if (q.dst)
                  d.credit = tick;
               if (last)
               begin
                  d.sub = '0;
                  d.seg = (q.seg == `MRF_SEG_HTERM) ? `MRF_SEG_FIRST
                                                    : q.seg + 1'b1;
               end
               else
                  d.sub = q.sub + 1'b1;
            end
         default: d.st = MRF_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q        <= '0;
         q.st     <= MRF_IDLE;
         q.fmt    <= MRF_FMT_TAB;
         q.hdr    <= 1'b1;
         q.credit <= 1'b1;
      end
      else
         q <= d;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_ser_cr_end: assert property (
      push && !q.dst && kind == K_TERM |-> chr == `MRF_CH_CR && last ##1
      kind == K_END || q.seg == `MRF_SEG_FIRST)
      else $error("serial line not ended by a single CR");
   a_ser_no_lf: assert property (
      push && !q.dst |-> fmt_if.data != `MRF_CH_LF)
      else $error("line feed sent on serial port");
   a_lim_col: assert property (
      push && kind == K_LIM |->
      chr == (q.lim ? `MRF_CH_FAIL : `MRF_CH_PASS) && q.seg == 4'h6)
      else $error("limit column out of place");
   a_num_point: assert property (
      push && kind inside {K_F0, K_F1, K_F2} && q.sub == `MRF_POS_DOT
      |-> chr == `MRF_CH_DOT)
      else $error("decimal point misplaced");
   a_num_expo: assert property (
      push && kind inside {K_F0, K_F1, K_F2} && q.sub == `MRF_POS_E
      |-> chr == `MRF_CH_E)
      else $error("exponent marker misplaced");
   a_err_digit: assert property (
      rd_valid && rd_ready && keep |=> q.err == $past(err_code[3:0]))
      else $error("error digit not taken from last code digit");
   a_sep_comma: assert property (
      push && kind == K_SEP && !q.sep_term |-> chr == `MRF_CH_COMMA)
      else $error("default separator not comma");
   a_dump_eoi: assert property (
      push && q.fmt == MRF_FMT_DMP |->
      fmt_if.eoi == (eoi_on && q.sub == `MRF_LEN_BIN - `MRF_LEN_ONE))
      else $error("EOI not on twelfth dump byte");
   a_dump_pure: assert property (
      q.st == MRF_RUN && q.fmt == MRF_FMT_DMP |-> kind inside {K_BIN, K_END})
      else $error("dump carries non-data bytes");
   a_sign_bit: assert property (
      push && kind == K_BIN && q.sub == 6'h04 |-> chr[7] == q.bf.sign)
      else $error("quadrature sign bit wrong");
   a_bus_pace: assert property (
      push && q.dst && !tick |=> !(push && q.dst))
      else $error("bus bytes faster than pacing");

   c_dump_eoi: cover property (push && q.fmt == MRF_FMT_DMP && fmt_if.eoi);
   c_cmp_done: cover property (push && q.fmt == MRF_FMT_CMP && last &&
                               kind == K_TERM);
   c_heading:  cover property (push && kind == K_HEAD && last);
   c_lost:     cover property (rd_lost);
endmodule

// file: mrf_map.svh
// Constants of the measurement result formatter
`ifndef MRF_MAP_SVH
`define MRF_MAP_SVH
`define MRF_CLK_MHZ       250
`define MRF_BYTE_TIME_US  1000
`define MRF_CH_CR         8'h0d
`define MRF_CH_LF         8'h0a
`define MRF_CH_COMMA      8'h2c
`define MRF_CH_SP         8'h20
`define MRF_CH_PLUS       8'h2b
`define MRF_CH_MINUS      8'h2d
`define MRF_CH_DOT        8'h2e
`define MRF_CH_E          8'h45
`define MRF_CH_ZERO       8'h30
`define MRF_CH_PASS       8'h50
`define MRF_CH_FAIL       8'h46
`define MRF_LEN_ONE       6'h01
`define MRF_LEN_CRLF      6'h02
`define MRF_LEN_CHAN      6'h02
`define MRF_LEN_NUM       6'h0b
`define MRF_LEN_BIN       6'h0c
`define MRF_LEN_HEAD      6'h2a
`define MRF_POS_DOT       6'h02
`define MRF_POS_E         6'h07
`define MRF_SEG_FIRST     4'h0
`define MRF_SEG_HEAD      4'hd
`define MRF_SEG_HTERM     4'he
`define MRF_HEAD_STR      "FREQUENCY   REAL/MAG    IMAG/PHASE  L CH T"
`endif

// file: mrf_pkg.sv
// Types shared by the measurement result formatter
package mrf_pkg;
   typedef enum logic [1:0] {
      MRF_TERM_CRLF     = 2'h0,
      MRF_TERM_CRLF_EOI = 2'h1,
      MRF_TERM_CR       = 2'h2,
      MRF_TERM_CR_EOI   = 2'h3
   } mrf_term_t;
   typedef enum logic [1:0] {
      MRF_SEL_ALL  = 2'h0,
      MRF_SEL_FAIL = 2'h1,
      MRF_SEL_PASS = 2'h2,
      MRF_SEL_DUMP = 2'h3
   } mrf_osel_t;
   typedef enum logic [2:0] {
      MRF_FMT_TAB = 3'b001,
      MRF_FMT_CMP = 3'b010,
      MRF_FMT_DMP = 3'b100
   } mrf_fmt_t;
   typedef enum logic [1:0] {
      MRF_IDLE = 2'b01,
      MRF_RUN  = 2'b10
   } mrf_st_t;
   typedef enum logic [3:0] {
      K_F0, K_F1, K_F2, K_SEP, K_SP, K_ERR, K_LIM,
      K_CH, K_TS, K_TERM, K_BIN, K_HEAD, K_END
   } mrf_kind_t;
   typedef struct packed {
      logic            sign;
      logic [4:0][3:0] dig;
      logic            esign;
      logic [1:0][3:0] exd;
   } mrf_num_t;
   typedef struct packed {
      logic        sign;
      logic [6:0]  expo;
      logic [23:0] mant;
   } mrf_flt_t;
endpackage

// file: mrf_byte_if.sv
// Byte stream between the formatter and its output buffer
`timescale 1ns/1ps
interface mrf_byte_if;
   logic [7:0] data;
   logic       eoi;
   logic       dst;
   logic       valid;
   logic       ready;
   modport src (output data, eoi, dst, valid, input ready);
   modport snk (input data, eoi, dst, valid, output ready);
endinterface

// file: mrf_buf2.sv
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module mrf_buf2
   import mrf_pkg::*;
#(
   parameter int DEPTH = 2
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Streams
   mrf_byte_if.snk   in_s,
   mrf_byte_if.src   out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][9:0] mem;
      logic [AW-1:0]         wp;
      logic [AW-1:0]         rp;
      logic [AW:0]           cnt;
   } mrf_buf_state_t;

   mrf_buf_state_t q;
   mrf_buf_state_t d;
   logic           wr;
   logic           rd;

   assign in_s.ready  = q.cnt != FULL;
   assign out_s.valid = q.cnt != '0;
   assign {out_s.data, out_s.eoi, out_s.dst} = q.mem[q.rp];

   always_comb
   begin
      d  = q;
      wr = in_s.valid && in_s.ready;
      rd = out_s.valid && out_s.ready;
      if (wr)
      begin
         d.mem[q.wp] = {in_s.data, in_s.eoi, in_s.dst};
         d.wp = (q.wp == LASTP) ? '0 : q.wp + 1'b1;
      end
      if (rd)
         d.rp = (q.rp == LASTP) ? '0 : q.rp + 1'b1;
      if (wr && !rd)
         d.cnt = q.cnt + 1'b1;
      else if (rd && !wr)
         d.cnt = q.cnt - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end
endmodule

// file: mrf_pace.sv
// Byte pacing divider: one-cycle tick per byte slot
`timescale 1ns/1ps
module mrf_pace
#(
   parameter int CYC = 250000
)
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   output logic      tick
);
   localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } mrf_pace_state_t;

   mrf_pace_state_t q;
   mrf_pace_state_t d;

   assign tick = q.tick;

   always_comb
   begin
      d      = q;
      d.tick = q.cnt == LAST;
      d.cnt  = (q.cnt == LAST) ? '0 : q.cnt + 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end
endmodule

// file: mrf_sink.sv
// Far-side byte consumer standing for a printer or a bus controller
`timescale 1ns/1ps
module mrf_sink
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Flow control
   input  wire logic stall,
   output logic      ready
);
   logic [1:0] cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 2'h0;
      else
         cnt_q <= cnt_q + 2'h1;
   end
   // A slow reader takes one slot in four but always drains in the end
   assign ready = !stall || (cnt_q == 2'h3);
endmodule

// file: mrf_formatter_tb.sv
// Self-checking bench of the measurement result formatter
`timescale 1ns/1ps
`include "mrf_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mrf_formatter_tb;
   import mrf_pkg::*;
   localparam int BC = 4;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       rd_valid = 1'b0;
   logic       rd_ready, rd_lost, ser_valid, bus_valid, bus_eoi;
   logic       ser_ready, bus_ready;
   logic [7:0] ser_data, bus_data;
   mrf_num_t   fn = {1'b0, 20'h12345, 1'b0, 8'h03};
   mrf_num_t   an = {1'b1, 20'h50000, 1'b1, 8'h01};
   mrf_num_t   bn = {1'b0, 20'h98765, 1'b0, 8'h12};
   mrf_flt_t   af = 32'hfe800000;
   mrf_flt_t   bf = 32'h3f123456;
   mrf_flt_t   ff = 32'h0a654321;
   logic [7:0] err_code = 8'h83;
   logic [7:0] chan_rng = 8'h12;
   logic [7:0] time_stat = 8'h2a;
   logic       lim_fail = 1'b1;
   logic       port_bus = 1'b0;
   mrf_osel_t  out_sel = MRF_SEL_ALL;
   mrf_term_t  term_sel = MRF_TERM_CRLF;
   logic       sep_term = 1'b0;
   logic       cont_mode = 1'b0;
   logic       bcast = 1'b0;
   logic       hdr_en = 1'b1;
   logic       ser_stall = 1'b1;
   logic       bus_stall = 1'b0;
   logic [9:0] got_q[$], exp_q[$];
   int         num_errors = 0, checked = 0, cyc = 0, last = 0, prev = 0;

   always #2 ref_clk = ~ref_clk;

   mrf_formatter #(.BYTE_CYC(BC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_lost(rd_lost),
      .freq_num(fn), .a_num(an), .b_num(bn), .a_flt(af), .b_flt(bf),
      .f_flt(ff), .err_code(err_code), .lim_fail(lim_fail),
      .chan_rng(chan_rng), .time_stat(time_stat), .port_bus(port_bus),
      .out_sel(out_sel), .term_sel(term_sel), .sep_term(sep_term),
      .hdr_en(hdr_en), .continuous_measure_mode(cont_mode),
      .printer_broadcast_switch(bcast), .ser_data(ser_data),
      .ser_valid(ser_valid), .ser_ready(ser_ready), .bus_data(bus_data),
      .bus_eoi(bus_eoi), .bus_valid(bus_valid), .bus_ready(bus_ready));
   mrf_sink i_ser_sink (.ref_clk(ref_clk), .rst_n(rst_n),
      .stall(ser_stall), .ready(ser_ready));
   mrf_sink i_bus_sink (.ref_clk(ref_clk), .rst_n(rst_n),
      .stall(bus_stall), .ready(bus_ready));

   always @(posedge ref_clk)
   begin
      cyc++;
      if (ser_valid && ser_ready)
         got_q.push_back({2'b00, ser_data});
      if (bus_valid && bus_ready)
      begin
         // A tick that meets a push keeps the credit, so two bytes may
         // sit one cycle apart; no third byte may follow inside a slot
         if (prev > 0)
            `CHK(cyc - prev >= BC, 1'b1)
         prev = last;
         last = cyc;
         got_q.push_back({1'b1, bus_eoi, bus_data});
      end
   end

   task summarize();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task put(input bit p, input bit e, input logic [7:0] d);
      exp_q.push_back({p, e, d});
   endtask
   task put_num(input bit p, input mrf_num_t n);
      put(p, 0, n.sign ? 8'h2d : 8'h2b);
      put(p, 0, {4'h3, n.dig[4]});
      put(p, 0, 8'h2e);
      for (int i = 3; i >= 0; i--)
         put(p, 0, {4'h3, n.dig[i]});
      put(p, 0, 8'h45);
      put(p, 0, n.esign ? 8'h2d : 8'h2b);
      put(p, 0, {4'h3, n.exd[1]});
      put(p, 0, {4'h3, n.exd[0]});
   endtask
   // Serial lines always end in CR alone; EOI only where e allows it
   task put_term(input bit p, input bit e);
      if (!p || term_sel[1])
         put(p, p && e && term_sel[0], 8'h0d);
      else
      begin
         put(p, 0, 8'h0d);
         put(p, e && term_sel[0], 8'h0a);
      end
   endtask
   task put_sep();
      if (sep_term)
         put_term(1, 0);
      else
         put(1, 0, 8'h2c);
   endtask
   // Heading goes out once, ahead of the first tabulated line
   task put_head(input bit p);
      logic [8*42-1:0] h;
      h = `MRF_HEAD_STR;
      for (int i = 41; i >= 0; i--)
         put(p, 0, h[8*i +: 8]);
      put_term(p, 1);
   endtask
   task put_tab(input bit p);
      put_num(p, fn);
      put(p, 0, 8'h20);
      put_num(p, an);
      put(p, 0, 8'h20);
      put_num(p, bn);
      put(p, 0, 8'h20);
      put(p, 0, lim_fail ? 8'h46 : 8'h50);
      put(p, 0, 8'h20);
      put(p, 0, {4'h3, chan_rng[7:4]});
      put(p, 0, {4'h3, chan_rng[3:0]});
      put(p, 0, 8'h20);
      put(p, 0, time_stat);
      put_term(p, 1);
   endtask
   task put_cmp();
      put_num(1, fn);
      put_sep();
      put_num(1, an);
      put_sep();
      put_num(1, bn);
      put_sep();
      put(1, 0, {4'h3, err_code[3:0]});
      put_term(1, 1);
   endtask
   task put_dump();
      logic [95:0] w;
      w = {af, bf, ff};
      for (int i = 11; i >= 0; i--)
         put(1, i == 0 && term_sel[0], w[8*i +: 8]);
   endtask
   task offer();
      int n;
      n = 0;
      rd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      rd_valid = 1'b0;
      repeat (2) @(posedge ref_clk);
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (!(rd_ready && !bus_valid && !ser_valid) && n < 3000);
      if (n >= 3000)
      begin
         num_errors++;
         summarize();
      end
   endtask
   task check();
      `CHK(got_q.size(), exp_q.size())
      foreach (exp_q[i])
         if (i < got_q.size())
            `CHK(got_q[i], exp_q[i])
      got_q.delete();
      exp_q.delete();
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      offer();
      put_head(0);
      put_tab(0);
      check();
      port_bus = 1'b1;
      bus_stall = 1'b1;
      for (int t = 0; t < 4; t++)
      begin
         term_sel = mrf_term_t'(t);
         sep_term = t[0];
         out_sel = MRF_SEL_ALL;
         offer();
         put_cmp();
         check();
         out_sel = MRF_SEL_DUMP;
         offer();
         put_dump();
         check();
      end
      bus_stall = 1'b0;
      sep_term = 1'b0;
      term_sel = MRF_TERM_CR;
      // Rejected readings are taken and dropped without output
      for (int s = 1; s < 3; s++)
         for (int l = 0; l < 2; l++)
         begin
            out_sel = mrf_osel_t'(s);
            lim_fail = l[0];
            offer();
            if ((s == 1) == l[0])
               put_cmp();
            check();
         end
      out_sel = MRF_SEL_ALL;
      bcast = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      offer();
      put_tab(1);
      check();
      cont_mode = 1'b1;
      rd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      `CHK(rd_lost, 1'b1)
      `CHK(rd_ready, 1'b0)
      offer();
      put_tab(1);
      check();
      summarize();
   end
endmodule
